// ### rtl/pac_axis_cmd.sv
// two-axis command handler: step change, aux code cancel, position preset
//
// Design decisions made here: the address map and register access over Wishbone.
`include "pac_map.svh"
`default_nettype none
module pac_axis_cmd import pac_pkg::*; #(
   parameter logic [15:0] STEP_MAX_STD = `PAC_STEP_STD,
   parameter logic [15:0] STEP_MAX_ADV = `PAC_STEP_ADV
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // commands from the sequence program
   input wire logic step_change_cmd,
   input wire logic aux_code_cancel_cmd,
   input wire logic position_preset_cmd,
   input wire logic [15:0] unit_slot_operand,
   input wire logic [15:0] axis_select_operand,
   input wire logic [31:0] command_value_operand,
   // motion engine side
   input wire logic [1:0] axis_busy,
   input wire logic [1:0] aux_code_set,
   input wire logic [1:0][15:0] aux_code_in,
   input wire logic [1:0] origin_lost,
   // axis state
   output logic [1:0][7:0] axis_step,
   output logic [1:0][31:0] axis_position,
   output logic [1:0] origin_fixed,
   output logic [1:0] aux_code_on,
   output logic [1:0][15:0] aux_code_num,
   output logic [1:0][15:0] axis_err_code,
   output logic error_flag,
   output logic irq
);

   // parameter sanity: step must fit the 8-bit step field
   if (STEP_MAX_STD < `PAC_STEP_MIN || STEP_MAX_ADV < STEP_MAX_STD || STEP_MAX_ADV > 16'h00ff) begin : g_bad
      $error("pac_axis_cmd: step limits out of range");
   end

   // state, next state and decoded command signals
   pac_state_t st;
   pac_state_t next_st;
   logic [1:0] rst_sync;
   logic rst_q_n;
   logic req;
   logic [2:0] cmd_now;
   logic [2:0] cmd_edge;
   logic ax;
   logic ax_ok;
   logic [1:0] ev_err;
   logic ev_done;
   logic [3:0] ev;
   logic [31:0] rd;

   // axis operand decode: only 0 and 1 are legal
   function automatic logic pac_axis_ok(input logic [15:0] v);
      return v[15:1] == 15'h0000;
   endfunction : pac_axis_ok

   // step range for the selected variant
   function automatic logic pac_step_ok(input logic [15:0] v, input logic adv);
      return v >= `PAC_STEP_MIN && v <= (adv ? STEP_MAX_ADV : STEP_MAX_STD);
   endfunction : pac_step_ok

   // reset release through two flops
   // the state register sees only the synchronised copy
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_q_n = rst_sync[1];

   // command edges and operand decode
   assign req = wb_cyc_i & wb_stb_i;
   assign cmd_now = {position_preset_cmd, aux_code_cancel_cmd, step_change_cmd};
   assign cmd_edge = cmd_now & ~st.cmd_prev;
   assign ax = axis_select_operand[0];
   assign ax_ok = pac_axis_ok(axis_select_operand);
   // slot operand is trusted to be zero and is not checked

   // next-state logic
   always_comb begin
      next_st = st;
      ev_err = 2'h0;
      ev_done = 1'b0;
      ev = 4'h0;
      rd = 32'h0000_0000;
      next_st.cmd_prev = cmd_now;
      next_st.ack = req & ~st.ack;
      // read data, latched at the same edge that raises ack
      case (wb_adr_i)
         `PAC_A_CTRL: rd = {31'h0, st.adv};
         `PAC_A_STATUS: rd = {25'h0, axis_busy, st.aux_on, st.origin, st.err_flag};
         `PAC_A_ERR_X: rd = {16'h0, st.err_code[0]};
         `PAC_A_ERR_Y: rd = {16'h0, st.err_code[1]};
         `PAC_A_STEP_X: rd = {24'h0, st.step[0]};
         `PAC_A_STEP_Y: rd = {24'h0, st.step[1]};
         `PAC_A_POS_X: rd = st.pos[0];
         `PAC_A_POS_Y: rd = st.pos[1];
         `PAC_A_AUX_X: rd = {16'h0, st.aux_num[0]};
         `PAC_A_AUX_Y: rd = {16'h0, st.aux_num[1]};
         `PAC_A_IRQ_STAT: rd = {28'h0, st.irq_stat};
         `PAC_A_IRQ_MASK: rd = {28'h0, st.irq_mask};
         default: rd = 32'h0000_0000;
      endcase
      if (req && !st.ack) begin
         next_st.rdata = rd;
      end
      // bus writes and read side effects at the ack edge
      if (req && st.ack && wb_we_i) begin
         case (wb_adr_i)
            `PAC_A_CTRL: begin
               if (wb_sel_i[0]) begin
                  next_st.adv = wb_dat_i[`PAC_CTRL_ADV];
                  if (wb_dat_i[`PAC_CTRL_CLRF]) begin
                     next_st.err_flag = 1'b0;
                  end
               end
            end
            `PAC_A_ERR_X: next_st.err_code[0] = 16'h0000;
            `PAC_A_ERR_Y: next_st.err_code[1] = 16'h0000;
            `PAC_A_IRQ_MASK: begin
               if (wb_sel_i[0]) begin
                  next_st.irq_mask = wb_dat_i[3:0];
               end
            end
            default: ;
         endcase
      end
      // clear only the bits the latched read returned, so an event
      // landing between latch and ack is kept for the next read
      if (req && st.ack && !wb_we_i && wb_adr_i == `PAC_A_IRQ_STAT) begin
         next_st.irq_stat = st.irq_stat & ~st.rdata[3:0];
      end
      // origin loss from the motion engine, before commands may fix it
      next_st.origin = st.origin & ~origin_lost;
      // command execution
      if (|cmd_edge && !ax_ok) begin
         next_st.err_flag = 1'b1;
      end else begin
         if (cmd_edge[0]) begin
            if (axis_busy[ax]) begin
               next_st.err_code[ax] = `PAC_E_STEP_BUSY;
               ev_err[ax] = 1'b1;
            end else if (!pac_step_ok(command_value_operand[15:0], st.adv)) begin
               next_st.err_code[ax] = `PAC_E_STEP_RANGE;
               ev_err[ax] = 1'b1;
            end else begin
               next_st.step[ax] = command_value_operand[7:0];
               ev_done = 1'b1;
            end
         end
         if (cmd_edge[1]) begin
            next_st.aux_on[ax] = 1'b0;
            next_st.aux_num[ax] = 16'h0000;
            ev_done = 1'b1;
         end
         if (cmd_edge[2]) begin
            if (axis_busy[ax]) begin
               next_st.err_code[ax] = `PAC_E_PRESET_BUSY;
               ev_err[ax] = 1'b1;
            end else begin
               next_st.pos[ax] = command_value_operand;
               next_st.origin[ax] = 1'b1;
               ev_done = 1'b1;
            end
         end
      end
      // a new aux code from the engine wins over a cancel
      for (int i = 0; i < 2; i++) begin
         if (aux_code_set[i]) begin
            next_st.aux_on[i] = 1'b1;
            next_st.aux_num[i] = aux_code_in[i];
         end
      end
      // sticky interrupt events, set wins over read clear
      ev = {ev_done, ev_err, (|cmd_edge) & ~ax_ok};
      next_st.irq_stat = next_st.irq_stat | ev;
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         st <= '0;
         st.step <= {`PAC_STEP_RST, `PAC_STEP_RST};
         st.irq_mask <= `PAC_MASK_RST;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign wb_dat_o = st.rdata;
   assign wb_ack_o = st.ack;
   assign axis_step = st.step;
   assign axis_position = st.pos;
   assign origin_fixed = st.origin;
   assign aux_code_on = st.aux_on;
   assign aux_code_num = st.aux_num;
   assign axis_err_code = st.err_code;
   assign error_flag = st.err_flag;
   assign irq = |(st.irq_stat & st.irq_mask);

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_q_n);

   // command steps used to build the properties
   sequence s_step_go;
      cmd_edge[0] && ax_ok && !axis_busy[ax];
   endsequence
   sequence s_preset_go;
      cmd_edge[2] && ax_ok;
   endsequence
   sequence s_held;
      step_change_cmd ##1 step_change_cmd;
   endsequence

   // command checks
   a_bad_axis_flag: assert property (|cmd_edge && !ax_ok |=> error_flag)
      else $error("bad axis did not set error flag");
   a_bad_axis_quiet: assert property (|cmd_edge && !ax_ok |=> $stable(axis_step) && $stable(axis_position))
      else $error("bad axis changed axis state");
   a_step_load: assert property (s_step_go ##0 pac_step_ok(command_value_operand[15:0], st.adv)
      |=> axis_step[$past(ax)] == $past(command_value_operand[7:0]))
      else $error("step not loaded");
   a_step_range: assert property (s_step_go ##0 !pac_step_ok(command_value_operand[15:0], st.adv)
      |=> axis_err_code[$past(ax)] == `PAC_E_STEP_RANGE && $stable(axis_step))
      else $error("step range error missing");
   a_step_busy: assert property (cmd_edge[0] && ax_ok && axis_busy[ax] && !cmd_edge[2]
      |=> axis_err_code[$past(ax)] == `PAC_E_STEP_BUSY && $stable(axis_step))
      else $error("step busy error missing");
   a_aux_cancel: assert property (cmd_edge[1] && ax_ok && !aux_code_set[ax]
      |=> !aux_code_on[$past(ax)] && aux_code_num[$past(ax)] == 16'h0000)
      else $error("aux code not cancelled");
   a_preset_load: assert property (s_preset_go ##0 !axis_busy[ax]
      |=> axis_position[$past(ax)] == $past(command_value_operand) && origin_fixed[$past(ax)])
      else $error("preset not applied");
   a_preset_busy: assert property (s_preset_go ##0 axis_busy[ax]
      |=> axis_err_code[$past(ax)] == `PAC_E_PRESET_BUSY && $stable(axis_position))
      else $error("preset busy error missing");
   a_edge_once: assert property (s_held |-> !cmd_edge[0])
      else $error("held command retriggered");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // bus answer, read data, interrupt event and error flag bookkeeping
   a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_read_step: assert property (req && !wb_ack_o && !wb_we_i && wb_adr_i == `PAC_A_STEP_X
      |=> wb_dat_o == {24'h0, $past(axis_step[0])})
      else $error("step read data wrong");
   a_event_sticky: assert property ((|cmd_edge) |=> st.irq_stat != 4'h0)
      else $error("command event not recorded");
   a_flag_hold: assert property (error_flag && !(req && wb_ack_o && wb_we_i && wb_adr_i == `PAC_A_CTRL)
      |=> error_flag)
      else $error("error flag dropped without a clear");
   a_flag_clear: assert property (req && wb_ack_o && wb_we_i && wb_adr_i == `PAC_A_CTRL && wb_sel_i[0]
      && wb_dat_i[`PAC_CTRL_CLRF] && !((|cmd_edge) && !ax_ok) |=> !error_flag)
      else $error("error flag not cleared");

   // axis state moves only on its own command, an engine event or a bus write that clears the error code
   a_step_hold: assert property (!cmd_edge[0] |=> $stable(axis_step))
      else $error("step changed without a command");
   a_pos_hold: assert property (!cmd_edge[2] |=> $stable(axis_position))
      else $error("position changed without a preset");
   a_err_keep: assert property (!(|cmd_edge) && !(req && wb_ack_o && wb_we_i) |=> $stable(axis_err_code))
      else $error("error code changed on its own");
   a_aux_hold: assert property (!cmd_edge[1] && aux_code_set == 2'h0
      |=> $stable(aux_code_on) && $stable(aux_code_num))
      else $error("aux code changed without a command");
   a_aux_post: assert property (aux_code_set[1] |=> aux_code_on[1] && aux_code_num[1] == $past(aux_code_in[1]))
      else $error("aux code from engine not taken");
   a_origin_drop: assert property (origin_lost[0] && !(cmd_edge[2] && ax_ok && !ax && !axis_busy[0])
      |=> !origin_fixed[0])
      else $error("origin loss ignored");

endmodule : pac_axis_cmd
`default_nettype wire

// ### rtl/pac_map.svh
// register offsets, field positions, reset values and codes of the axis command handler
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH
// byte offsets on the register bus
`define PAC_A_CTRL 8'h00
`define PAC_A_STATUS 8'h04
`define PAC_A_ERR_X 8'h08
`define PAC_A_ERR_Y 8'h0c
`define PAC_A_STEP_X 8'h10
`define PAC_A_STEP_Y 8'h14
`define PAC_A_POS_X 8'h18
`define PAC_A_POS_Y 8'h1c
`define PAC_A_AUX_X 8'h20
`define PAC_A_AUX_Y 8'h24
`define PAC_A_IRQ_STAT 8'h28
`define PAC_A_IRQ_MASK 8'h2c
// control fields
`define PAC_CTRL_ADV 0
`define PAC_CTRL_CLRF 1
// interrupt fields
`define PAC_IRQ_GERR 0
`define PAC_IRQ_ERRX 1
`define PAC_IRQ_ERRY 2
`define PAC_IRQ_DONE 3
// reset values
`define PAC_STEP_RST 8'h01
`define PAC_MASK_RST 4'h0
// axis error codes
`define PAC_E_STEP_BUSY 16'h01b9
`define PAC_E_STEP_RANGE 16'h01ba
`define PAC_E_PRESET_BUSY 16'h01c3
// step range limits
`define PAC_STEP_MIN 16'h0001
`define PAC_STEP_STD 16'h001e
`define PAC_STEP_ADV 16'h0050
`endif

// ### rtl/pac_pkg.sv
// types of the axis command handler
`default_nettype none
package pac_pkg;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [2:0] cmd_prev;
      logic adv;
      logic err_flag;
      logic [1:0][15:0] err_code;
      logic [1:0][7:0] step;
      logic [1:0][31:0] pos;
      logic [1:0] origin;
      logic [1:0] aux_on;
      logic [1:0][15:0] aux_num;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
   } pac_state_t;
endpackage : pac_pkg
`default_nettype wire

// ### verification/pac_seq_model.sv
// model of the sequence program and motion engine that drive the axis command handler
`default_nettype none
module pac_seq_model (
   // clock
   input wire logic sys_clk,
   // command levels and operands
   output logic [2:0] cmd,
   output logic [15:0] slot,
   output logic [15:0] axis,
   output logic [31:0] value,
   // motion engine events
   output logic [1:0] busy,
   output logic [1:0] aux_set,
   output logic [1:0][15:0] aux_in,
   output logic [1:0] lost
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle levels at time zero
   initial begin
      cmd = 3'h0;
      slot = 16'h0000;
      axis = 16'h0000;
      value = 32'h0000_0000;
      busy = 2'h0;
      aux_set = 2'h0;
      aux_in = '0;
      lost = 2'h0;
   end

   // raise one command for len cycles; operands go stale once taken
   task automatic fire(input int k, input logic [15:0] ax, input logic [31:0] v, input int len);
      @(posedge sys_clk);
      cmd[k] <= 1'b1;
      axis <= ax;
      value <= v;
      slot <= 16'h0000;
      @(posedge sys_clk);
      axis <= ~ax;
      value <= ~v;
      repeat (len - 1) @(posedge sys_clk);
      cmd <= 3'h0;
      @(posedge sys_clk);
      #1;
   endtask : fire

   // axis motion level
   task automatic set_busy(input logic [1:0] b);
      @(posedge sys_clk);
      busy <= b;
   endtask : set_busy

   // one-cycle engine pulses: aux code posted, origin lost
   task automatic pulse(input logic [1:0] a, input logic [1:0] lo, input logic [15:0] n);
      @(posedge sys_clk);
      aux_set <= a;
      lost <= lo;
      aux_in <= {n, n};
      @(posedge sys_clk);
      aux_set <= 2'h0;
      lost <= 2'h0;
      aux_in <= {~n, ~n};
      @(posedge sys_clk);
      #1;
   endtask : pulse
endmodule : pac_seq_model
`default_nettype wire

// ### verification/tb_pac_axis_cmd.sv
// self-checking bench of the axis command handler
`include "pac_map.svh"
`default_nettype none
module tb_pac_axis_cmd;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst_n, cyc, stb, we, ack, irq, error_flag;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd, val;
   logic [2:0] cmd;
   logic [15:0] slot, axsel;
   logic [1:0] busy, aux_set, lost, ofix, aon;
   logic [1:0][15:0] aux_in, anum, ecode;
   logic [1:0][7:0] step;
   logic [1:0][31:0] pos;
   int err_total, tests_run;

   pac_axis_cmd i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .step_change_cmd(cmd[0]), .aux_code_cancel_cmd(cmd[1]), .position_preset_cmd(cmd[2]),
      .unit_slot_operand(slot), .axis_select_operand(axsel), .command_value_operand(val),
      .axis_busy(busy), .aux_code_set(aux_set), .aux_code_in(aux_in), .origin_lost(lost),
      .axis_step(step), .axis_position(pos), .origin_fixed(ofix), .aux_code_on(aon),
      .aux_code_num(anum), .axis_err_code(ecode), .error_flag(error_flag), .irq(irq));
   pac_seq_model i_seq (.sys_clk(sys_clk), .cmd(cmd), .slot(slot), .axis(axsel), .value(val),
      .busy(busy), .aux_set(aux_set), .aux_in(aux_in), .lost(lost));

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // counts, verdict, end of run
   task automatic results();
      $display("compared %0d, mismatched %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // classic single wishbone cycle, ack sampled at the edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: bus timeout", $time);
         results();
      end else begin
         rd = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask : wb

   // hang guard
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      $display("mismatch at %0t: run timeout", $time);
      results();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, adr, sel, wdat} = '0;
      err_total = 0;
      tests_run = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      chk(step, 16'h0101);
      chk(irq, 1'b0);
      i_seq.fire(0, 16'h0000, 32'd5, 1);
      chk(step, 16'h0105);
      i_seq.fire(0, 16'h0001, 32'd30, 1);
      chk(step[1], 8'h1e);
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, `PAC_A_ERR_Y, 32'h0);
         #1;
         chk(ecode[1], 16'h0000);
         i_seq.fire(0, 16'h0001, i ? 32'h0000_0101 : 32'd31, 1);
         chk(ecode[1], `PAC_E_STEP_RANGE);
      end
      i_seq.fire(0, 16'h0001, 32'd0, 1);
      chk(step[1], 8'h1e);
      wb(1'b1, `PAC_A_CTRL, 32'h1);
      i_seq.fire(0, 16'h0001, 32'd80, 1);
      chk(step[1], 8'h50);
      wb(1'b1, `PAC_A_CTRL, 32'h0);
      i_seq.fire(0, 16'h0000, 32'd7, 4);
      chk(step[0], 8'h07);
      chk(ecode[0], 16'h0000);
      chk(error_flag, 1'b0);
      wb(1'b0, `PAC_A_STEP_X, 32'h0);
      chk(rd, 32'h7);
      $display("step tests done");
      i_seq.set_busy(2'b01);
      i_seq.fire(0, 16'h0000, 32'd9, 1);
      chk({ecode[0], 8'h00, step[0]}, {`PAC_E_STEP_BUSY, 16'h0007});
      i_seq.fire(2, 16'h0000, 32'h1234, 1);
      chk(ecode[0], `PAC_E_PRESET_BUSY);
      chk(pos[0], 32'h0);
      i_seq.set_busy(2'b00);
      wb(1'b1, `PAC_A_IRQ_MASK, 32'h2);
      #1;
      chk(irq, 1'b1);
      wb(1'b0, `PAC_A_IRQ_STAT, 32'h0);
      chk(rd, 32'he);
      #1;
      chk(irq, 1'b0);
      wb(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0);
      $display("busy and interrupt tests done");
      i_seq.fire(2, 16'h0002, 32'h55, 1);
      i_seq.fire(0, 16'hffff, 32'd3, 1);
      chk(error_flag, 1'b1);
      chk(pos[0], 32'h0);
      chk(pos[1], 32'h0);
      chk(step, 16'h5007);
      i_seq.fire(2, 16'h0000, 32'h8000_0000, 1);
      i_seq.fire(2, 16'h0001, 32'h7fff_ffff, 1);
      chk(pos[0], 32'h8000_0000);
      chk(pos[1], 32'h7fff_ffff);
      chk(ofix, 2'b11);
      wb(1'b0, `PAC_A_STATUS, 32'h0);
      chk(rd, 32'h7);
      wb(1'b1, `PAC_A_CTRL, 32'h2);
      #1;
      chk(error_flag, 1'b0);
      i_seq.pulse(2'b10, 2'b01, 16'h0123);
      chk(ofix, 2'b10);
      chk({aon, anum[1]}, {2'b10, 16'h0123});
      i_seq.fire(2, 16'h0000, 32'h0, 1);
      chk(ofix, 2'b11);
      i_seq.fire(1, 16'h0001, 32'h0, 1);
      chk({aon, anum[1]}, 18'h0);
      $display("preset and aux tests done");
      results();
   end
endmodule : tb_pac_axis_cmd
`default_nettype wire
